// file: hw/mdcb_top.sv
// Command decoder, per-bank state and small data array of a four-bank mobile DDR memory.
// Assumes all pins are asynchronous to mclk and the memory clock is far slower than mclk.
//
// Function
// - Deselect or no-op registers nothing; running operations continue.
// - Activate opens address row in the selected bank until it is precharged.
// - Read to open bank starts burst at column A0-A9; A10 asks auto precharge.
// - Read with auto precharge closes row after burst; otherwise row stays open.
// - Write to open bank starts burst; A10 closes row after burst.
// - Each write beat stores a byte only when its mask bit is low.
// - Precharge closes selected bank, or all banks when A10 is high.
// - Precharged bank becomes idle after precharge period; controller activates before access.
// - Precharge to idle or already precharging bank does nothing.
// - Accesses to other banks accepted while an auto-precharge burst runs.
// - Auto precharge starts at earliest legal point, honouring row active minimum.
// - Burst terminate cuts latest read without auto precharge; row stays open.
// - Auto refresh uses internal row counter, ignores address; controller repeats it.
// - Refresh encoding with clock enable low enters self refresh; only enable matters.
// - Self refresh keeps only banks chosen by partial array setting; oscillator paced.
// - All banks idle, burst-terminate encoding with enable low enters deep power-down.
// - Deep power-down discards array contents; enable high leaves it.
// - Strobe patterns decode to activate, read, write, terminate, precharge, refresh; the mode set pattern is not decoded.
`timescale 1ns/1ps
`include "mdcb_consts.svh"
module mdcb_top #(
  parameter int DW = 16,
  parameter int COL_W = 10,
  parameter int ROW_W = 14,
  parameter int SR_OSC_CYC = `MDCB_SELF_REFRESH_OSC_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Memory bus pins
  input wire logic mem_ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_bit0,
  input wire logic bank_select_bit1,
  input wire logic [ROW_W-1:0] addr,
  input wire logic [DW/8-1:0] write_byte_mask,
  input wire logic [DW-1:0] wr_data,
  // Configuration
  input wire logic [1:0] burst_len_code,
  input wire logic [2:0] partial_array_refresh_setting,
  // Read data stream
  output logic [DW-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  // Status
  output logic [3:0] bank_open,
  output mdcb_pkg::mdcb_pwr_e power_state,
  output logic [ROW_W-1:0] refresh_row,
  output logic burst_busy
);
  import mdcb_pkg::*;

  localparam int MW = DW / 8;
  localparam int SW = 8 + ROW_W + MW + DW;
  localparam int WORDS = 4 * (1 << COL_W);
  localparam logic [7:0] PRE_CYC = 8'(`MDCB_PRECHARGE_PERIOD_CYC);
  localparam logic [7:0] RAS_CYC = 8'(`MDCB_ROW_ACTIVE_MIN_CYC);
  localparam logic [7:0] RFC_CYC = 8'(`MDCB_REFRESH_CYCLE_CYC);
  localparam logic [7:0] XSR_CYC = 8'(`MDCB_SELF_REFRESH_EXIT_CYC);
  localparam logic [15:0] OSC_CYC = 16'(SR_OSC_CYC);

  // ==================================================================
  // Pin synchronisers: two flops, then a third for edge detection
  logic [SW-1:0] s1, s2;
  logic ck_d;
  logic [2:0] warm;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s1 <= '0;
      s2 <= '0;
      ck_d <= 1'b0;
      warm <= 3'h0;
    end else begin
      s1 <= {mem_ck, cke, cs_n, ras_n, cas_n, we_n, bank_select_bit1, bank_select_bit0,
             addr, write_byte_mask, wr_data};
      s2 <= s1;
      ck_d <= s2[SW-1];
      warm <= {warm[1:0], 1'b1};
    end
  end
  logic p_ck, p_cke, p_cs_n;
  logic [2:0] p_strobe;
  logic [1:0] p_bank;
  logic [ROW_W-1:0] p_addr;
  logic [MW-1:0] p_mask;
  logic [DW-1:0] p_data;
  assign {p_ck, p_cke, p_cs_n, p_strobe, p_bank, p_addr, p_mask, p_data} = s2;
  logic ck_rise, ck_edge;
  // Edges count only once the pipeline holds real pin samples, else reset fakes a rise
  assign ck_rise = warm[2] & p_ck & ~ck_d;
  assign ck_edge = warm[2] & (p_ck ^ ck_d);

  // ==================================================================
  // Command decode
  logic cke_prev, next_cke_prev;
  mdcb_pwr_e pwr, next_pwr;
  logic [3:0] bst_idle;
  logic sel, all_idle, auto_pre;
  logic c_act, c_rd, c_wr, c_bt, c_pre, c_aref, c_sref, c_deep;
  always_comb begin
    next_cke_prev = ck_rise ? p_cke : cke_prev;
    // Deselect and the no_operation_cmd pattern fall through all arms
    sel = ck_rise && !p_cs_n && cke_prev && pwr == PWR_NORMAL;
    all_idle = &bst_idle;
    auto_pre = p_addr[`MDCB_AUTO_PRE_BIT];
    c_act = sel && p_cke && p_strobe == 3'b011;
    c_rd = sel && p_cke && p_strobe == 3'b101;
    c_wr = sel && p_cke && p_strobe == 3'b100;
    c_bt = sel && p_cke && p_strobe == 3'b110;
    c_pre = sel && p_cke && p_strobe == 3'b010;
    c_aref = sel && p_cke && p_strobe == 3'b001 && all_idle;
    c_sref = sel && !p_cke && p_strobe == 3'b001 && all_idle;
    c_deep = sel && !p_cke && p_strobe == 3'b110 && all_idle;
  end

  // ==================================================================
  // Data burst state; a single data bus, so one burst at a time
  logic b_on, b_wr, b_auto;
  logic [1:0] b_bank;
  logic [COL_W-1:0] b_col;
  logic [4:0] b_left;
  logic next_b_on, next_b_wr, next_b_auto;
  logic [1:0] next_b_bank;
  logic [COL_W-1:0] next_b_col, wrap;
  logic [4:0] next_b_left;
  logic [3:0] bank_act;
  logic f_in_ready, f_push, beat, b_end;
  logic mem_we;
  logic [MW-1:0] mem_be;
  always_comb begin
    next_b_on = b_on;
    next_b_wr = b_wr;
    next_b_auto = b_auto;
    next_b_bank = b_bank;
    next_b_col = b_col;
    next_b_left = b_left;
    wrap = COL_W'((5'h1 << burst_len_code) - 5'h1);
    if (burst_len_code == 2'h0) begin
      wrap = COL_W'(5'h0f);
    end
    // Read beats wait for buffer room so a stalled reader loses nothing
    beat = b_on && ck_edge && (b_wr || f_in_ready);
    f_push = beat && !b_wr;
    mem_we = beat && b_wr;
    mem_be = ~p_mask;
    b_end = beat && b_left == 5'h1;
    if (beat) begin
      next_b_col = (b_col & ~wrap) | ((b_col + COL_W'(1)) & wrap);
      next_b_left = b_left - 5'h1;
      next_b_on = !b_end;
    end
    if (c_bt && b_on && !b_wr && !b_auto) begin
      next_b_on = 1'b0;
    end
    // A new access truncates the running burst
    if ((c_rd || c_wr) && bank_act[p_bank]) begin
      next_b_on = 1'b1;
      next_b_wr = c_wr;
      next_b_auto = auto_pre;
      next_b_bank = p_bank;
      next_b_col = p_addr[COL_W-1:0];
      next_b_left = burst_len_code == 2'h0 ? 5'h10 : 5'(5'h1 << burst_len_code);
    end
    if (c_pre && b_on && (auto_pre || p_bank == b_bank)) begin
      next_b_on = 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      b_on <= 1'b0;
      b_wr <= 1'b0;
      b_auto <= 1'b0;
      b_bank <= 2'h0;
      b_col <= '0;
      b_left <= 5'h0;
    end else begin
      b_on <= next_b_on;
      b_wr <= next_b_wr;
      b_auto <= next_b_auto;
      b_bank <= next_b_bank;
      b_col <= next_b_col;
      b_left <= next_b_left;
    end
  end
  assign burst_busy = b_on;

  // ==================================================================
  // Per-bank state
  mdcb_bank_e bst [4];
  logic [ROW_W-1:0] brow [4];
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_bank
      mdcb_bank_e next_st;
      logic [7:0] tmr, next_tmr, ras, next_ras;
      logic pend, next_pend, hit, own_burst;
      logic [ROW_W-1:0] next_row;
      always_comb begin
        next_st = bst[g];
        next_tmr = tmr;
        next_ras = (ras < RAS_CYC) ? ras + 8'h1 : ras;
        next_pend = pend;
        next_row = brow[g];
        hit = p_bank == 2'(g);
        own_burst = next_b_on && next_b_bank == 2'(g);
        case (bst[g])
          BANK_IDLE: begin
            if (c_act && hit) begin
              next_st = BANK_ACTIVE;
              next_row = p_addr;
              next_ras = 8'h0;
              next_pend = 1'b0;
            end
          end
          BANK_ACTIVE: begin
            if ((c_rd || c_wr) && hit) begin
              next_pend = auto_pre;
            end
            if (c_pre && (auto_pre || hit)) begin
              next_st = BANK_PRECHARGING;
              next_tmr = PRE_CYC;
            end else if (next_pend && !own_burst && ras >= RAS_CYC) begin
              next_st = BANK_PRECHARGING;
              next_tmr = PRE_CYC;
            end
          end
          BANK_PRECHARGING: begin
            // Further precharges are ignored here
            next_tmr = tmr - 8'h1;
            if (tmr <= 8'h1) begin
              next_st = BANK_IDLE;
              next_pend = 1'b0;
            end
          end
          default: begin
            next_st = BANK_IDLE;
          end
        endcase
      end
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          bst[g] <= BANK_IDLE;
          tmr <= 8'h0;
          ras <= 8'h0;
          pend <= 1'b0;
          brow[g] <= '0;
        end else begin
          bst[g] <= next_st;
          tmr <= next_tmr;
          ras <= next_ras;
          pend <= next_pend;
          brow[g] <= next_row;
        end
      end
      assign bst_idle[g] = bst[g] == BANK_IDLE;
      assign bank_act[g] = bst[g] == BANK_ACTIVE;
      assign bank_open[g] = bst[g] != BANK_IDLE;
      a_act_opens_row: assert property (@(posedge mclk) disable iff (!reset_n)
        c_act && p_bank == 2'(g) && bst[g] == BANK_IDLE
        |=> bst[g] == BANK_ACTIVE && brow[g] == $past(p_addr))
        else $error("activate did not open the row");
      a_pre_idle_time: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(bst[g] == BANK_PRECHARGING) |-> bst[g] == BANK_PRECHARGING [*1]
        ##(`MDCB_PRECHARGE_PERIOD_CYC) bst[g] == BANK_IDLE)
        else $error("bank did not go idle after the precharge period");
    end
  endgenerate

  // ==================================================================
  // Power modes and refresh
  logic [7:0] p_tmr, next_p_tmr;
  logic [15:0] osc, next_osc;
  logic [ROW_W-1:0] next_rrow;
  logic [3:0] keep, wipe;
  always_comb begin
    next_pwr = pwr;
    next_p_tmr = p_tmr > 8'h0 ? p_tmr - 8'h1 : 8'h0;
    next_osc = osc;
    next_rrow = refresh_row;
    wipe = 4'h0;
    keep = partial_array_refresh_setting == `MDCB_PARTIAL_ARRAY_REFRESH_SETTING_FULL ? 4'hf :
           partial_array_refresh_setting == `MDCB_PARTIAL_ARRAY_REFRESH_SETTING_HALF ? 4'h3 : 4'h1;
    case (pwr)
      PWR_NORMAL: begin
        if (c_aref) begin
          next_rrow = refresh_row + ROW_W'(1);
          next_p_tmr = RFC_CYC;
        end
        if (c_sref) begin
          next_pwr = PWR_SELF_REFRESH;
          next_osc = 16'h0;
          wipe = ~keep;
        end
        if (c_deep) begin
          next_pwr = PWR_DEEP_DOWN;
          wipe = 4'hf;
        end
      end
      PWR_SELF_REFRESH: begin
        // Paced by mclk alone since the memory clock may stop here
        next_osc = osc + 16'h1;
        if (osc >= OSC_CYC - 16'h1) begin
          next_osc = 16'h0;
          next_rrow = refresh_row + ROW_W'(1);
        end
        if (p_cke) begin
          next_pwr = PWR_SR_EXIT;
          next_p_tmr = XSR_CYC;
        end
      end
      PWR_SR_EXIT: begin
        if (p_tmr <= 8'h1) begin
          next_pwr = PWR_NORMAL;
        end
      end
      PWR_DEEP_DOWN: begin
        if (p_cke) begin
          next_pwr = PWR_NORMAL;
        end
      end
      default: begin
        next_pwr = PWR_NORMAL;
      end
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pwr <= PWR_NORMAL;
      p_tmr <= 8'h0;
      osc <= 16'h0;
      refresh_row <= '0;
      cke_prev <= 1'b0;
    end else begin
      pwr <= next_pwr;
      p_tmr <= next_p_tmr;
      osc <= next_osc;
      refresh_row <= next_rrow;
      cke_prev <= next_cke_prev;
    end
  end
  assign power_state = pwr;

  // ==================================================================
  // Data array; a location reads as zero until written with no byte masked since its last loss
  logic [DW-1:0] mem [WORDS];
  logic [WORDS-1:0] written;
  logic [COL_W+1:0] widx;
  logic [DW-1:0] rword;
  assign widx = {b_bank, b_col};
  assign rword = written[widx] ? mem[widx] : '0;
  // One process owns the array; byte lanes are masked inside it
  always_ff @(posedge mclk) begin
    for (int l = 0; l < MW; l++) begin
      if (mem_we && mem_be[l]) begin
        mem[widx][8*l +: 8] <= p_data[8*l +: 8];
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      written <= '0;
    end else begin
      for (int i = 0; i < WORDS; i++) begin
        if (wipe[i >> COL_W]) begin
          written[i] <= 1'b0;
        end
      end
      if (mem_we && mem_be == {MW{1'b1}}) begin
        written[widx] <= 1'b1;
      end
    end
  end

  // ==================================================================
  // Two-entry read buffer
  logic [DW-1:0] f_data [2];
  logic f_wp, f_rp;
  logic [1:0] f_cnt;
  logic f_pop;
  assign f_in_ready = f_cnt != 2'h2;
  assign f_pop = rd_valid && rd_ready;
  assign rd_valid = f_cnt != 2'h0;
  assign rd_data = f_data[f_rp];
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      f_wp <= 1'b0;
      f_rp <= 1'b0;
      f_cnt <= 2'h0;
      f_data[0] <= '0;
      f_data[1] <= '0;
    end else begin
      if (f_push) begin
        f_data[f_wp] <= rword;
        f_wp <= ~f_wp;
      end
      if (f_pop) begin
        f_rp <= ~f_rp;
      end
      f_cnt <= f_cnt + 2'(f_push) - 2'(f_pop);
    end
  end

  // ==================================================================
  // Checks
  a_idle_cmd_keeps: assert property (@(posedge mclk) disable iff (!reset_n)
    ck_rise && (p_cs_n || p_strobe == 3'b111) && pwr == PWR_NORMAL && !beat
    |=> $stable(b_on) && $stable(b_col))
    else $error("deselect or no-op changed the burst");
  a_read_starts: assert property (@(posedge mclk) disable iff (!reset_n)
    c_rd && bank_act[p_bank] |=> b_on && !b_wr && b_bank == $past(p_bank)
    && b_col == $past(p_addr[COL_W-1:0]))
    else $error("read did not start a burst");
  a_pre_all_banks: assert property (@(posedge mclk) disable iff (!reset_n)
    c_pre && auto_pre |=> bank_act == 4'h0)
    else $error("precharge all left a bank active");
  a_term_read: assert property (@(posedge mclk) disable iff (!reset_n)
    c_bt && b_on && !b_wr && !b_auto && !c_rd && !c_wr
    |=> !b_on && bank_act[b_bank])
    else $error("burst terminate did not end the read");
  a_sref_entry: assert property (@(posedge mclk) disable iff (!reset_n)
    c_sref |=> pwr == PWR_SELF_REFRESH)
    else $error("self refresh not entered");
  a_deep_entry: assert property (@(posedge mclk) disable iff (!reset_n)
    c_deep |=> pwr == PWR_DEEP_DOWN ##1 written == '0)
    else $error("deep power-down did not discard data");
  a_sr_exit_wait: assert property (@(posedge mclk) disable iff (!reset_n)
    pwr == PWR_SELF_REFRESH && p_cke |=> pwr == PWR_SR_EXIT
    ##(`MDCB_SELF_REFRESH_EXIT_CYC) pwr == PWR_NORMAL)
    else $error("self refresh exit timing wrong");
  a_no_late_cke: assert property (@(posedge mclk) disable iff (!reset_n)
    ck_rise && !cke_prev && pwr == PWR_NORMAL && !beat
    |=> $stable(b_on) && $stable(refresh_row) && pwr == PWR_NORMAL)
    else $error("command taken with enable low before");
  a_buf_stall: assert property (@(posedge mclk) disable iff (!reset_n)
    b_on && !b_wr && f_cnt == 2'h2 && !f_pop |=> $stable(b_col))
    else $error("read burst advanced into a full buffer");
endmodule : mdcb_top

// file: common/mdcb_consts.svh
// Constants of the mobile DDR command and bank control block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef MDCB_CONSTS_SVH
`define MDCB_CONSTS_SVH

// ==================================================================
// Clock and timing
`define MDCB_MCLK_PS 50000
`define MDCB_PRECHARGE_PERIOD_NS 18
`define MDCB_ROW_ACTIVE_MIN_NS 42
`define MDCB_REFRESH_CYCLE_NS 72
`define MDCB_SELF_REFRESH_EXIT_NS 112
`define MDCB_SELF_REFRESH_OSC_NS 7800
// Least times round up to whole cycles
`define MDCB_CYC_UP(ns) (((ns) * 1000 + `MDCB_MCLK_PS - 1) / `MDCB_MCLK_PS)
`define MDCB_PRECHARGE_PERIOD_CYC `MDCB_CYC_UP(`MDCB_PRECHARGE_PERIOD_NS)
`define MDCB_ROW_ACTIVE_MIN_CYC `MDCB_CYC_UP(`MDCB_ROW_ACTIVE_MIN_NS)
`define MDCB_REFRESH_CYCLE_CYC `MDCB_CYC_UP(`MDCB_REFRESH_CYCLE_NS)
`define MDCB_SELF_REFRESH_EXIT_CYC `MDCB_CYC_UP(`MDCB_SELF_REFRESH_EXIT_NS)
`define MDCB_SELF_REFRESH_OSC_CYC `MDCB_CYC_UP(`MDCB_SELF_REFRESH_OSC_NS)

// ==================================================================
// Address fields
`define MDCB_AUTO_PRE_BIT 10
`define MDCB_PARTIAL_ARRAY_REFRESH_SETTING_FULL 3'h0
`define MDCB_PARTIAL_ARRAY_REFRESH_SETTING_HALF 3'h1

`endif

// file: common/mdcb_pkg.sv
// Types of the mobile DDR command and bank control block.
// Assumes the constants header is on the include path.
package mdcb_pkg;
  `include "mdcb_consts.svh"

  // ==================================================================
  // Bank states
  typedef enum logic [1:0] {
    BANK_IDLE = 2'b00,
    BANK_ACTIVE = 2'b01,
    BANK_PRECHARGING = 2'b10
  } mdcb_bank_e;

  // ==================================================================
  // Power states
  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_SELF_REFRESH = 2'b01,
    PWR_SR_EXIT = 2'b10,
    PWR_DEEP_DOWN = 2'b11
  } mdcb_pwr_e;
endpackage : mdcb_pkg

// file: tb/mdcb_ctl_model.sv
// Memory controller model: makes the memory clock, drives commands, address and write beats.
// Assumes mclk runs at eight times the memory clock rate and is shared with the block.
`timescale 1ns/1ps
module mdcb_ctl_model (
  // Clock
  input wire logic mclk,
  // Memory bus pins
  output logic mem_ck,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic bank_select_bit0,
  output logic bank_select_bit1,
  output logic [13:0] addr,
  output logic [1:0] write_byte_mask,
  output logic [15:0] wr_data
);
  logic [2:0] ph;
  logic [15:0] wdat;
  logic [1:0] wmsk;

  initial begin
    ph = 3'h0;
    mem_ck = 1'b1;
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    {bank_select_bit1, bank_select_bit0} = 2'h0;
    addr = 14'h0;
    write_byte_mask = 2'h3;
    wr_data = 16'h0;
    wdat = 16'h0;
    wmsk = 2'h0;
  end

  // ==================================================================
  // Memory clock, eight mclk per period
  // Runs free: the block leaves its low-power states without any edge
  always @(posedge mclk) begin
    ph <= ph + 3'h1;
    mem_ck <= (ph + 3'h1) < 3'h4;
  end

  // ==================================================================
  // Commands
  // Launched at the falling edge, held across the rising edge, then a no-op
  // with a changed address, so a stale command is never seen twice
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a,
                     input logic ke);
    do @(posedge mclk); while (ph != 3'h3);
    {cs_n, ras_n, cas_n, we_n} <= c;
    {bank_select_bit1, bank_select_bit0} <= b;
    addr <= a;
    cke <= ke;
    wr_data <= (c == 4'h4) ? wdat : ~wr_data;
    write_byte_mask <= (c == 4'h4) ? wmsk : ~write_byte_mask;
    // A whole period per command outlasts every precharge, refresh and exit wait
    repeat (7) @(posedge mclk);
    {cs_n, ras_n, cas_n, we_n} <= 4'h7;
    addr <= ~a;
  endtask : cmd

  // Write of two beats: first beat spans the next fall, second the rise after
  task automatic wr(input logic [1:0] b, input logic [13:0] a, input logic [15:0] d0,
                    input logic [1:0] m0, input logic [15:0] d1, input logic [1:0] m1);
    wdat = d0;
    wmsk = m0;
    cmd(4'h4, b, a, 1'b1);
    repeat (3) @(posedge mclk);
    wr_data <= d1;
    write_byte_mask <= m1;
    repeat (4) @(posedge mclk);
    wr_data <= ~d1;
    write_byte_mask <= ~m1;
  endtask : wr
endmodule : mdcb_ctl_model

// file: tb/mdcb_top_tb.sv
// Self-checking bench of the mobile DDR command and bank control block.
// Assumes the controller model in mdcb_ctl_model.sv and the design package.
`timescale 1ns/1ps
module mdcb_top_tb;
  import mdcb_pkg::*;
  localparam logic [3:0] C_NOP = 4'h7, C_ACT = 4'h3, C_RD = 4'h5, C_BST = 4'h6;
  localparam logic [3:0] C_PRE = 4'h2, C_REF = 4'h1, C_MRS = 4'h0, C_DES = 4'hb;
  localparam logic [13:0] ALL = 14'h0400;
  logic mclk, reset_n, rd_ready, mem_ck, cke, cs_n, ras_n, cas_n, we_n;
  logic bank_select_bit0, bank_select_bit1, rd_valid, burst_busy;
  logic [13:0] addr, refresh_row;
  logic [1:0] write_byte_mask, burst_len_code;
  logic [2:0] partial_array_refresh_setting;
  logic [15:0] wr_data, rd_data;
  logic [3:0] bank_open;
  mdcb_pwr_e power_state;
  logic [15:0] got[$];
  int compares = 0;
  int fail_count = 0;

  mdcb_ctl_model ctl (.mclk, .mem_ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_bit0,
    .bank_select_bit1, .addr, .write_byte_mask, .wr_data);
  mdcb_top #(.SR_OSC_CYC(8)) DUT (.mclk, .reset_n, .mem_ck, .cke, .cs_n, .ras_n, .cas_n, .we_n,
    .bank_select_bit0, .bank_select_bit1, .addr, .write_byte_mask, .wr_data, .burst_len_code,
    .partial_array_refresh_setting, .rd_data, .rd_valid, .rd_ready, .bank_open, .power_state,
    .refresh_row, .burst_busy);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Words taken from the read stream, in order
  always @(posedge mclk) begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1) got.push_back(rd_data);
  end

  // ==================================================================
  // Compare and closing tasks
  task automatic note(input logic bad, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (bad) begin
      fail_count++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask : note

  task automatic chk_stat(input logic [4:0] e);
    repeat (4) @(negedge mclk);
    note({burst_busy, bank_open} !== e, {11'h0, e}, {11'h0, burst_busy, bank_open});
  endtask : chk_stat

  task automatic chk_pwr(input mdcb_pwr_e e);
    repeat (4) @(negedge mclk);
    note(power_state !== e, {14'h0, e}, {14'h0, power_state});
  endtask : chk_pwr

  task automatic chk_row(input logic [13:0] e);
    repeat (4) @(negedge mclk);
    note(refresh_row !== e, {2'h0, e}, {2'h0, refresh_row});
  endtask : chk_row

  task automatic chk_rd(input logic [15:0] e);
    logic [15:0] g;
    int n;
    n = 0;
    while (got.size() == 0 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    g = (got.size() == 0) ? ~e : got.pop_front();
    note(g !== e, e, g);
  endtask : chk_rd

  task automatic end_sim();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic op(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a);
    ctl.cmd(c, b, a, 1'b1);
  endtask : op

  task automatic rd(input logic [1:0] b, input logic [9:0] col, input logic ap);
    op(C_RD, b, {3'h0, ap, col});
  endtask : rd

  // About forty times the expected run
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    end_sim();
  end

  // ==================================================================
  // Tests
  initial begin
    reset_n = 1'b0;
    rd_ready = 1'b1;
    burst_len_code = 2'h1;
    partial_array_refresh_setting = 3'h0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    chk_stat(5'h00);
    chk_pwr(PWR_NORMAL);
    op(C_NOP, 2'h0, 14'h0);
    op(C_DES, 2'h1, 14'h0123);
    chk_stat(5'h00);
    op(C_MRS, 2'h0, 14'h0);
    op(C_PRE, 2'h1, 14'h0);
    chk_stat(5'h00);
    op(C_ACT, 2'h1, 14'h0123);
    chk_stat(5'h02);
    ctl.wr(2'h1, 14'h0004, 16'h1234, 2'h0, 16'h5678, 2'h0);
    ctl.wr(2'h1, 14'h0004, 16'haaff, 2'h1, 16'h77ee, 2'h2);
    // Reader stalls across two bursts: the second must wait, not drop words
    rd_ready <= 1'b0;
    rd(2'h1, 10'h4, 1'b0);
    rd(2'h1, 10'h4, 1'b0);
    note(rd_valid !== 1'b1, 16'h1, {15'h0, rd_valid});
    rd_ready <= 1'b1;
    chk_rd(16'haa34);
    chk_rd(16'h56ee);
    chk_rd(16'haa34);
    chk_rd(16'h56ee);
    chk_stat(5'h02);
    rd(2'h1, 10'h4, 1'b1);
    chk_rd(16'haa34);
    chk_rd(16'h56ee);
    chk_stat(5'h00);
    op(C_ACT, 2'h0, 14'h0010);
    op(C_ACT, 2'h1, 14'h0123);
    rd(2'h0, 10'h0, 1'b1);
    rd(2'h1, 10'h4, 1'b0);
    chk_rd(16'h0000);
    chk_rd(16'h0000);
    chk_rd(16'haa34);
    chk_rd(16'h56ee);
    chk_stat(5'h02);
    @(posedge mclk);
    burst_len_code <= 2'h0;
    rd(2'h1, 10'h4, 1'b0);
    op(C_BST, 2'h0, 14'h0);
    chk_stat(5'h02);
    got.delete();
    @(posedge mclk);
    burst_len_code <= 2'h1;
    op(C_ACT, 2'h0, 14'h0010);
    op(C_ACT, 2'h2, 14'h0020);
    op(C_PRE, 2'h2, 14'h0);
    chk_stat(5'h03);
    op(C_PRE, 2'h1, ALL);
    chk_stat(5'h00);
    op(C_REF, 2'h3, 14'h1fff);
    chk_row(14'h0001);
    op(C_ACT, 2'h0, 14'h0010);
    ctl.wr(2'h0, 14'h0008, 16'h1111, 2'h0, 16'h2222, 2'h0);
    op(C_PRE, 2'h0, ALL);
    partial_array_refresh_setting <= 3'h2;
    ctl.cmd(C_REF, 2'h0, 14'h0, 1'b0);
    chk_pwr(PWR_SELF_REFRESH);
    ctl.cmd(C_ACT, 2'h1, 14'h0, 1'b0);
    ctl.cmd(C_NOP, 2'h0, 14'h0, 1'b1);
    chk_pwr(PWR_NORMAL);
    chk_stat(5'h00);
    op(C_NOP, 2'h0, 14'h0);
    op(C_ACT, 2'h0, 14'h0010);
    op(C_ACT, 2'h1, 14'h0123);
    rd(2'h0, 10'h8, 1'b0);
    rd(2'h1, 10'h4, 1'b0);
    chk_rd(16'h1111);
    chk_rd(16'h2222);
    chk_rd(16'h0000);
    chk_rd(16'h0000);
    op(C_PRE, 2'h0, ALL);
    ctl.cmd(C_BST, 2'h0, 14'h0, 1'b0);
    chk_pwr(PWR_DEEP_DOWN);
    ctl.cmd(C_NOP, 2'h0, 14'h0, 1'b1);
    chk_pwr(PWR_NORMAL);
    op(C_NOP, 2'h0, 14'h0);
    op(C_ACT, 2'h0, 14'h0010);
    rd(2'h0, 10'h8, 1'b0);
    chk_rd(16'h0000);
    chk_rd(16'h0000);
    end_sim();
  end
endmodule : mdcb_top_tb
